//--- core/ltwc_top.sv
`timescale 1ns/10ps

// Functional notes
// - 13-bit counter, not software visible, zero after reset, counts each clock outside halt.
// - overflow event when counter wraps from 1F39h to zero.
// - overflow events 1 ms apart; period select doubles the spacing.
// - overflow sets timebase flag; interrupt when flag and enable both set.
// - reading the control/status byte clears the timebase flag.
// - enabled watchdog resets the device after 2 ms without refresh.
// - software sets delay bit to refresh; hardware clears it each period.
// - watchdog period runs from reset; late enable may reset at once.
// - setting force bit while enabled forces a watchdog reset.
// - force bit stays set after watchdog reset; a read clears it.
// - uncleared source flag resets the device at the next enable.
// - hardware watchdog option keeps watchdog on, ignores enable bit.
// - in halt the counter stops and no watchdog reset occurs.
// - after halt wake, watchdog resumes after 256 or 512 clocks.
// - capture pin edge latches counter upper eight bits.
// - capture sets capture flag, interrupt if enabled; register read clears it.
// - further edges ignored while the capture flag is set.
// - counter runs in wait and active-halt, stops in halt.
// - separate requests; timebase wakes wait and active-halt, capture wait only.
// - source flag cleared by hardware only on low-voltage reset.
// - writes to either flag position leave the flag unchanged.
module ltwc_top
	import ltwc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic lvd_rst_n,
	input wire logic halt_mode,
	input wire logic halt_resume_long,
	input wire logic hw_dog_option,
	input wire logic csr_wr,
	input wire logic [CSR_W-1:0] csr_wdata,
	input wire logic csr_rd,
	input wire logic capture_rd,
	input wire logic capture_input_pin,
	output logic [CSR_W-1:0] timer_ctrl_status_reg,
	output logic [CAP_W-1:0] capture_value_reg,
	output logic irq_timebase,
	output logic irq_capture,
	output logic wake_from_wait,
	output logic wake_from_active_halt,
	output logic wake_from_halt,
	output logic dog_reset
);

	logic [CNT_W-1:0] count_q;
	logic tb_phase_q;
	logic period_select;
	logic overflow_flag;
	logic overflow_irq_en;
	logic capture_flag;
	logic capture_irq_en;
	logic dog_enable;
	logic dog_delay_refresh;
	logic dog_force_reset_flag;
	logic cap_sync;
	logic cap_prev_q;
	logic cap_edge;
	logic cap_take;
	logic ovf;
	logic tb_event;
	logic dog_on;

	// ------------------------------------------------------------
	// free-running counter
	// ------------------------------------------------------------
	// halts with the oscillator, runs in wait and active-halt
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			count_q <= CNT_ZERO;
		else if (!halt_mode)
		begin
			if (count_q == CNT_TERM)
				count_q <= CNT_ZERO;
			else
				count_q <= count_q + CNT_ONE;
		end
	end

	// wrap from terminal count
	assign ovf = !halt_mode && (count_q == CNT_TERM);

	// ------------------------------------------------------------
	// timebase
	// ------------------------------------------------------------
	// every other overflow counts when the long period is chosen
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tb_phase_q <= 1'b0;
		else if (ovf)
			tb_phase_q <= !tb_phase_q;
	end

	assign tb_event = ovf && (!period_select || tb_phase_q);

	// flag: hardware set wins over the read clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			overflow_flag <= 1'b0;
		else if (tb_event)
			overflow_flag <= 1'b1;
		else if (csr_rd)
			overflow_flag <= 1'b0;
	end

	// ------------------------------------------------------------
	// software control bits
	// ------------------------------------------------------------
	// enables and period select written from the control byte
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			capture_irq_en <= 1'b0;
			period_select <= 1'b0;
			overflow_irq_en <= 1'b0;
			dog_enable <= 1'b0;
		end
		else if (csr_wr)
		begin
			capture_irq_en <= csr_wdata[BIT_CAP_IE];
			period_select <= csr_wdata[BIT_PSEL];
			overflow_irq_en <= csr_wdata[BIT_TB_IE];
			dog_enable <= csr_wdata[BIT_DOG_EN];
		end
	end

	// option strap overrides the software enable
	assign dog_on = hw_dog_option || dog_enable;

	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------
	// period, refresh, expiry, forced reset and source flag
	ltwc_wdog u_wdog (
		.clk(clk),
		.rst_n(rst_n),
		.lvd_rst_n(lvd_rst_n),
		.ovf_tick(ovf),
		.halt_mode(halt_mode),
		.resume_long(halt_resume_long),
		.dog_on(dog_on),
		.csr_rd(csr_rd),
		.flag_wr(csr_wr),
		.flag_wdata(csr_wdata[BIT_DOG_RF]),
		.delay_set(csr_wr && csr_wdata[BIT_DOG_DLY]),
		.delay_q(dog_delay_refresh),
		.flag_q(dog_force_reset_flag),
		.dog_reset(dog_reset)
	);

	// ------------------------------------------------------------
	// input capture
	// ------------------------------------------------------------
	// pin resynchronised before any edge logic
	ltwc_sync u_cap_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(capture_input_pin),
		.sync_out(cap_sync)
	);

	// both edges are detected on the synchronised level
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cap_prev_q <= 1'b0;
		else
			cap_prev_q <= cap_sync;
	end

	assign cap_edge = cap_sync ^ cap_prev_q;
	assign cap_take = cap_edge && !capture_flag;

	// latch upper counter bits on an accepted edge
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			capture_value_reg <= CAP_RST;
		else if (cap_take)
			capture_value_reg <= count_q[CAP_MSB:CAP_LSB];
	end

	// capture flag: new capture wins over the read clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			capture_flag <= 1'b0;
		else if (cap_take)
			capture_flag <= 1'b1;
		else if (capture_rd)
			capture_flag <= 1'b0;
	end

	// ------------------------------------------------------------
	// status byte and requests
	// ------------------------------------------------------------
	// status byte assembled from live state
	always_comb
	begin
		timer_ctrl_status_reg = '0;
		timer_ctrl_status_reg[BIT_CAP_IE] = capture_irq_en;
		timer_ctrl_status_reg[BIT_CAP_F] = capture_flag;
		timer_ctrl_status_reg[BIT_PSEL] = period_select;
		timer_ctrl_status_reg[BIT_TB_IE] = overflow_irq_en;
		timer_ctrl_status_reg[BIT_TB_F] = overflow_flag;
		timer_ctrl_status_reg[BIT_DOG_RF] = dog_force_reset_flag;
		timer_ctrl_status_reg[BIT_DOG_EN] = dog_enable;
		timer_ctrl_status_reg[BIT_DOG_DLY] = dog_delay_refresh;
	end

	// separate requests and their wake reach
	assign irq_timebase = overflow_flag && overflow_irq_en;
	assign irq_capture = capture_flag && capture_irq_en;
	assign wake_from_wait = irq_timebase || irq_capture;
	assign wake_from_active_halt = irq_timebase;
	assign wake_from_halt = 1'b0;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	cnt_wrap_a: assert property (count_q == CNT_TERM && !halt_mode |=> count_q == CNT_ZERO)
		else $error("counter did not wrap at terminal count");

	cnt_halt_a: assert property (halt_mode |=> $stable(count_q))
		else $error("counter moved during halt");

	tb_set_a: assert property (tb_event |=> overflow_flag ##0 $rose(overflow_flag) or $past(overflow_flag))
		else $error("overflow did not set timebase flag");

	tb_read_a: assert property (csr_rd && !tb_event |=> !overflow_flag)
		else $error("status read left timebase flag set");

	tb_double_a: assert property (ovf && period_select && !tb_phase_q |=> !$rose(overflow_flag))
		else $error("long period flagged on odd overflow");

	tb_spacing_a: assert property (tb_event |=> !tb_event [*8])
		else $error("timebase events too close");

	cap_take_a: assert property (cap_take |=>
		capture_flag && capture_value_reg == $past(count_q[CAP_MSB:CAP_LSB]))
		else $error("capture not latched with flag");

	cap_hold_a: assert property (capture_flag && !capture_rd |=> $stable(capture_value_reg)
		&& capture_flag)
		else $error("capture changed while flag set");

	cap_wr_a: assert property (csr_wr && !cap_take && !capture_rd |=> $stable(capture_flag))
		else $error("write changed capture flag");

	dog_halt_a: assert property (halt_mode [*2] |-> !dog_reset)
		else $error("watchdog reset during halt");

	dog_flag_a: assert property (dog_reset |-> dog_force_reset_flag)
		else $error("watchdog reset without source flag");

	dog_hw_a: assert property (hw_dog_option && dog_force_reset_flag && !halt_mode
		|=> dog_reset)
		else $error("hardware watchdog ignored source flag");

	dog_force_a: assert property (csr_wr && csr_wdata[BIT_DOG_RF] && dog_on && !halt_mode
		##1 !halt_mode |=> dog_reset)
		else $error("forced reset not issued");

	// ------------------------------------------------------------
	// counter, timebase and capture checks
	// ------------------------------------------------------------
	cnt_run_a: assert property (!halt_mode && count_q != CNT_TERM
		|=> count_q == $past(count_q) + CNT_ONE)
		else $error("counter did not advance by one");

	tb_short_a: assert property (ovf && !period_select |=> overflow_flag)
		else $error("short period overflow not flagged");

	tb_long_a: assert property (ovf && period_select && tb_phase_q |=> overflow_flag)
		else $error("long period overflow not flagged");

	tb_hold_a: assert property (overflow_flag && !csr_rd |=> overflow_flag)
		else $error("timebase flag dropped without read");

	tb_wr_a: assert property (csr_wr && !tb_event && !csr_rd |=> $stable(overflow_flag))
		else $error("write changed timebase flag");

	tb_irq_a: assert property (overflow_flag && overflow_irq_en
		|-> irq_timebase && wake_from_wait && wake_from_active_halt)
		else $error("timebase request missing");

	cap_irq_a: assert property (capture_flag && capture_irq_en
		|-> irq_capture && wake_from_wait)
		else $error("capture request missing");

	cap_ah_a: assert property (!irq_timebase |-> !wake_from_active_halt)
		else $error("active-halt wake without timebase request");

	halt_wake_a: assert property (!wake_from_halt)
		else $error("request claims wake from halt");

	cap_clr_a: assert property (capture_rd && !cap_take |=> !capture_flag)
		else $error("capture read left flag set");

	ctl_wr_a: assert property (csr_wr |=> capture_irq_en == $past(csr_wdata[BIT_CAP_IE])
		&& period_select == $past(csr_wdata[BIT_PSEL]))
		else $error("capture enable or period select not written");

	en_wr_a: assert property (csr_wr |=> dog_enable == $past(csr_wdata[BIT_DOG_EN])
		&& overflow_irq_en == $past(csr_wdata[BIT_TB_IE]))
		else $error("watchdog or timebase enable not written");

	// ------------------------------------------------------------
	// watchdog checks
	// ------------------------------------------------------------
	dly_set_a: assert property (csr_wr && csr_wdata[BIT_DOG_DLY] |=> dog_delay_refresh)
		else $error("refresh write did not set delay bit");

	dly_hold_a: assert property (dog_delay_refresh && !ovf |=> dog_delay_refresh)
		else $error("delay bit cleared between periods");

	dog_off_a: assert property (!dog_on |=> !dog_reset)
		else $error("watchdog reset while disabled");

	dog_keep_a: assert property (dog_reset && dog_on && !halt_mode |=> dog_reset)
		else $error("watchdog reset request dropped");

	src_wr_a: assert property (csr_wr && csr_wdata[BIT_DOG_RF] |=> dog_force_reset_flag)
		else $error("force write did not set source flag");

	src_rd_a: assert property (csr_rd && !dog_on && !(csr_wr && csr_wdata[BIT_DOG_RF])
		|=> !dog_force_reset_flag)
		else $error("status read left source flag set");

	// a low-voltage reset is the one legal way the flag drops unasked
	src_keep_a: assert property (disable iff (!rst_n || !lvd_rst_n)
		dog_force_reset_flag && !csr_rd && !csr_wr |=> dog_force_reset_flag)
		else $error("source flag lost without software clear");

	cap_seen_c: cover property (cap_take ##1 capture_rd);
	tb_short_c: cover property (!period_select && tb_event);
	halt_exit_c: cover property ($fell(halt_mode));
	tb_long_c: cover property (period_select && tb_event);
	dog_fire_c: cover property (!dog_force_reset_flag ##1 dog_reset);

endmodule : ltwc_top

//--- core/ltwc_pkg.sv
package ltwc_pkg;

	// ------------------------------------------------------------
	// free-running counter
	// ------------------------------------------------------------
	localparam int CNT_W = 13;
	localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;
	localparam logic [CNT_W-1:0] CNT_TERM = 13'h1F39;
	localparam int CAP_MSB = 12;
	localparam int CAP_LSB = 5;
	localparam int CAP_W = 8;
	localparam logic [CAP_W-1:0] CAP_RST = 8'h00;

	// ------------------------------------------------------------
	// timing figures, in milliseconds, overflow periods and clocks
	// ------------------------------------------------------------
	localparam int TB_PERIOD_MS = 1;
	localparam int DOG_TIMEOUT_MS = 2;
	localparam int DOG_PERIOD_OVF = DOG_TIMEOUT_MS / TB_PERIOD_MS;
	localparam int DOG_PER_W = 2;
	localparam logic [DOG_PER_W-1:0] DOG_PER_LAST = DOG_PER_W'(DOG_PERIOD_OVF - 1);
	localparam logic [DOG_PER_W-1:0] DOG_PER_ZERO = 2'h0;
	localparam logic [DOG_PER_W-1:0] DOG_PER_ONE = 2'h1;
	localparam int RESUME_W = 10;
	localparam logic [RESUME_W-1:0] RESUME_SHORT = 10'h100;
	localparam logic [RESUME_W-1:0] RESUME_LONG = 10'h200;
	localparam logic [RESUME_W-1:0] RESUME_ZERO = 10'h000;
	localparam logic [RESUME_W-1:0] RESUME_ONE = 10'h001;

	// ------------------------------------------------------------
	// control/status byte layout
	// ------------------------------------------------------------
	localparam int CSR_W = 8;
	localparam int BIT_CAP_IE = 7;
	localparam int BIT_CAP_F = 6;
	localparam int BIT_PSEL = 5;
	localparam int BIT_TB_IE = 4;
	localparam int BIT_TB_F = 3;
	localparam int BIT_DOG_RF = 2;
	localparam int BIT_DOG_EN = 1;
	localparam int BIT_DOG_DLY = 0;

endpackage : ltwc_pkg

//--- core/ltwc_sync.sv
`timescale 1ns/10ps

// two-stage synchroniser for the capture pin
module ltwc_sync
	import ltwc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);

	logic meta_q;

	// ------------------------------------------------------------
	// metastability chain
	// ------------------------------------------------------------
	// first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : ltwc_sync

//--- core/ltwc_wdog.sv
`timescale 1ns/10ps

// watchdog period, refresh, expiry and reset-source flag
module ltwc_wdog
	import ltwc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic lvd_rst_n,
	input wire logic ovf_tick,
	input wire logic halt_mode,
	input wire logic resume_long,
	input wire logic dog_on,
	input wire logic csr_rd,
	input wire logic flag_wr,
	input wire logic flag_wdata,
	input wire logic delay_set,
	output logic delay_q,
	output logic flag_q,
	output logic dog_reset
);

	logic [RESUME_W-1:0] resume_q;
	logic halt_prev_q;
	logic [DOG_PER_W-1:0] per_q;
	logic expired_q;
	logic read_seen_q;
	logic tick;
	logic period_end;
	logic fire;

	// ------------------------------------------------------------
	// halt exit delay before counting resumes
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			halt_prev_q <= 1'b0;
			resume_q <= RESUME_ZERO;
		end
		else
		begin
			halt_prev_q <= halt_mode;
			if (halt_prev_q && !halt_mode)
				resume_q <= resume_long ? RESUME_LONG : RESUME_SHORT;
			else if (resume_q != RESUME_ZERO)
				resume_q <= resume_q - RESUME_ONE;
		end
	end

	assign tick = ovf_tick && (resume_q == RESUME_ZERO);
	assign period_end = tick && (per_q == DOG_PER_LAST);

	// ------------------------------------------------------------
	// period counted from reset, not from enabling
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			per_q <= DOG_PER_ZERO;
		else if (period_end)
			per_q <= DOG_PER_ZERO;
		else if (tick)
			per_q <= per_q + DOG_PER_ONE;
	end

	// refresh bit: software set wins over hardware clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			delay_q <= 1'b0;
		else if (delay_set)
			delay_q <= 1'b1;
		else if (period_end)
			delay_q <= 1'b0;
	end

	// timeout seen without a refresh, kept until refreshed
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			expired_q <= 1'b0;
		else if (delay_set)
			expired_q <= 1'b0;
		else if (period_end && !delay_q)
			expired_q <= 1'b1;
	end

	// ------------------------------------------------------------
	// reset request, held until the device reset lands
	// ------------------------------------------------------------
	assign fire = dog_on && !halt_mode && (expired_q || flag_q);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			dog_reset <= 1'b0;
		else
			dog_reset <= fire;
	end

	// read of the status byte arms a software clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			read_seen_q <= 1'b0;
		else if (csr_rd)
			read_seen_q <= 1'b1;
	end

	// source flag survives all but the low-voltage reset
	always_ff @(posedge clk or negedge lvd_rst_n)
	begin
		if (!lvd_rst_n)
			flag_q <= 1'b0;
		else if (fire || (flag_wr && flag_wdata))
			flag_q <= 1'b1;
		else if (csr_rd || (flag_wr && read_seen_q))
			flag_q <= 1'b0;
	end

endmodule : ltwc_wdog

//--- dv/ltwc_pin_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// capture pin source
// ----------------------------------------
// flips the pin a little after a clock edge when asked
module ltwc_pin_model
(
	input wire logic clk,
	input wire logic toggle,
	output logic capture_input_pin
);
	initial capture_input_pin = 1'b0;

	// late change keeps the pin off the sampling edge
	always @(posedge clk)
	begin
		if (toggle)
			capture_input_pin <= #3 ~capture_input_pin;
	end
endmodule : ltwc_pin_model

//--- dv/test_lite_timebase_watchdog_capture.sv
`timescale 1ns/10ps

// ----------------------------------------
// lite timer bench
// ----------------------------------------
module test_lite_timebase_watchdog_capture
	import ltwc_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic lvd_rst_n = 1'b0;
	logic halt_mode = 1'b0;
	logic halt_resume_long = 1'b0;
	logic hw_dog_option = 1'b0;
	logic csr_wr = 1'b0;
	logic [CSR_W-1:0] csr_wdata = 8'h00;
	logic csr_rd = 1'b0;
	logic capture_rd = 1'b0;
	logic toggle = 1'b0;
	logic capture_input_pin;
	logic [CSR_W-1:0] timer_ctrl_status_reg;
	logic [CAP_W-1:0] capture_value_reg;
	logic irq_timebase;
	logic irq_capture;
	logic wake_from_wait;
	logic wake_from_active_halt;
	logic wake_from_halt;
	logic dog_reset;
	int miscompares = 0;
	int num_checks = 0;
	int now = 0;
	int n = 0;
	localparam int TB_GAP = int'(CNT_TERM) + 1;

	always #5 clk = ~clk;

	ltwc_top DUT (.clk(clk), .rst_n(rst_n), .lvd_rst_n(lvd_rst_n), .halt_mode(halt_mode),
		.halt_resume_long(halt_resume_long), .hw_dog_option(hw_dog_option), .csr_wr(csr_wr),
		.csr_wdata(csr_wdata), .csr_rd(csr_rd), .capture_rd(capture_rd),
		.capture_input_pin(capture_input_pin), .timer_ctrl_status_reg(timer_ctrl_status_reg),
		.capture_value_reg(capture_value_reg), .irq_timebase(irq_timebase),
		.irq_capture(irq_capture), .wake_from_wait(wake_from_wait),
		.wake_from_active_halt(wake_from_active_halt), .wake_from_halt(wake_from_halt),
		.dog_reset(dog_reset));

	ltwc_pin_model pin_src (.clk(clk), .toggle(toggle), .capture_input_pin(capture_input_pin));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task end_sim;
		if (miscompares == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task cyc(input int k);
		repeat (k) @(negedge clk);
		now += k;
	endtask : cyc

	function automatic logic get(input int s);
		return (s == 8) ? dog_reset : timer_ctrl_status_reg[s];
	endfunction : get

	// bounded poll; sel 8 is the watchdog reset, else a status bit
	task waitfor(input int s, input logic v, input int lim);
		n = 0;
		while (get(s) !== v)
		begin
			if (n >= lim)
			begin
				miscompares++;
				$display("MISMATCH wait_%0d expected %h seen timeout", s, v);
				end_sim();
			end
			cyc(1);
			n++;
		end
	endtask : waitfor

	task wr(input logic [7:0] d);
		csr_wdata = d;
		csr_wr = 1'b1;
		cyc(1);
		csr_wr = 1'b0;
	endtask : wr

	task rd;
		csr_rd = 1'b1;
		cyc(1);
		csr_rd = 1'b0;
	endtask : rd

	task caprd;
		capture_rd = 1'b1;
		cyc(1);
		capture_rd = 1'b0;
	endtask : caprd

	// pin edge at a set count after the last wrap, then settle
	task capt(input int at);
		cyc(at - now);
		toggle = 1'b1;
		cyc(1);
		toggle = 1'b0;
		cyc(8);
	endtask : capt

	task rst;
		rst_n = 1'b0;
		cyc(5);
		rst_n = 1'b1;
	endtask : rst

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial
	begin
		cyc(5);
		rst_n = 1'b1;
		lvd_rst_n = 1'b1;
		chk("csr_rst", timer_ctrl_status_reg, 8'h00);
		chk("cap_rst", capture_value_reg, CAP_RST);
		// timebase spacing, flag, request, clear on read
		wr(8'h10);
		waitfor(BIT_TB_F, 1'b1, 16'h2000);
		chk("irq_tb", irq_timebase, 1'b1);
		chk("wake_ah", wake_from_active_halt, 1'b1);
		chk("wake_h", wake_from_halt, 1'b0);
		rd;
		chk("tb_f_clr", timer_ctrl_status_reg[BIT_TB_F], 1'b0);
		waitfor(BIT_TB_F, 1'b1, 16'h2000);
		chk("tb_gap", 16'(n), 16'(CNT_TERM));
		rd;
		wr(8'h58);
		chk("flag_wr", timer_ctrl_status_reg, 8'h10);
		chk("irq_tb_off", irq_timebase, 1'b0);
		// capture: both edges, inhibit while flagged, clear on read
		wr(8'h80);
		waitfor(BIT_TB_F, 1'b1, 16'h2000);
		now = 0;
		rd;
		capt(16'h1EA);
		chk("cap_f", timer_ctrl_status_reg[BIT_CAP_F], 1'b1);
		chk("cap_v1", capture_value_reg, 8'h0F);
		chk("irq_cap", irq_capture, 1'b1);
		chk("wake_w", wake_from_wait, 1'b1);
		chk("wake_ah_cap", wake_from_active_halt, 1'b0);
		capt(16'h50A);
		chk("cap_hold", capture_value_reg, 8'h0F);
		caprd;
		chk("cap_f_clr", timer_ctrl_status_reg[BIT_CAP_F], 1'b0);
		chk("irq_cap_off", irq_capture, 1'b0);
		capt(16'hAEA);
		chk("cap_v2", capture_value_reg, 8'h57);
		caprd;
		capt(16'h1EEA);
		chk("cap_v3", capture_value_reg, 8'hF7);
		caprd;
		// doubled period
		wr(8'h30);
		waitfor(BIT_TB_F, 1'b1, 16'h4000);
		rd;
		waitfor(BIT_TB_F, 1'b1, 16'h4000);
		chk("tb_gap2", 16'(n), 16'(2 * TB_GAP - 1));
		// late enable, source flag across reset
		wr(8'h02);
		waitfor(8, 1'b1, 4);
		chk("src_set", timer_ctrl_status_reg[BIT_DOG_RF], 1'b1);
		rst;
		chk("src_keep", timer_ctrl_status_reg[BIT_DOG_RF], 1'b1);
		chk("dog_rel", dog_reset, 1'b0);
		wr(8'h02);
		waitfor(8, 1'b1, 4);
		chk("src_refire", dog_reset, 1'b1);
		rst;
		rd;
		chk("src_rd_clr", timer_ctrl_status_reg[BIT_DOG_RF], 1'b0);
		// forced reset
		wr(8'h02);
		cyc(4);
		chk("dog_early", dog_reset, 1'b0);
		wr(8'h06);
		waitfor(8, 1'b1, 4);
		chk("dog_force", dog_reset, 1'b1);
		rst;
		rd;
		// refresh once, then let it expire
		wr(8'h03);
		waitfor(BIT_DOG_DLY, 1'b0, 16'h4000);
		chk("dly_keep", dog_reset, 1'b0);
		waitfor(8, 1'b1, 16'h4000);
		chk("dog_span", {15'h0000, n >= 2 * TB_GAP - 4 && n <= 2 * TB_GAP + 4}, 16'h0001);
		chk("src_wd", timer_ctrl_status_reg[BIT_DOG_RF], 1'b1);
		// low-voltage reset clears the source flag, then strap forces the watchdog on
		rst;
		lvd_rst_n = 1'b0;
		cyc(2);
		lvd_rst_n = 1'b1;
		chk("src_lvd", timer_ctrl_status_reg[BIT_DOG_RF], 1'b0);
		hw_dog_option = 1'b1;
		cyc(2);
		chk("hw_quiet", dog_reset, 1'b0);
		wr(8'h04);
		waitfor(8, 1'b1, 4);
		chk("hw_dog", dog_reset, 1'b1);
		hw_dog_option = 1'b0;
		rst;
		rd;
		// halt freezes counter and watchdog
		wr(8'h13);
		halt_mode = 1'b1;
		cyc(16'h4000);
		chk("halt_dog", dog_reset, 1'b0);
		chk("halt_tb", timer_ctrl_status_reg[BIT_TB_F], 1'b0);
		halt_mode = 1'b0;
		end_sim();
	end
endmodule : test_lite_timebase_watchdog_capture
